// file: flash_bus_cycle.sv
`timescale 1ns/10ps
`include "flash_status_defs.svh"
module flash_bus_cycle
    import flash_status_pkg::*;
#(
    parameter int ADDR_W = 22
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    flash_cycle_if.engine      cyc,
    output logic [ADDR_W-1:0]  flashAddr,
    output flash_word_t        dataOut,
    output logic               dataOe_b,
    input  wire flash_word_t   dataIn,
    output logic               chipSelect_b,
    output logic               outputEnable_b,
    output logic               writeStrobe_b
);
    bus_state_e  state;
    logic [3:0]  count;
    logic        isWrite;
    flash_word_t rdataReg;
    logic        doneReg;

    wire strobeEnd = (count == 4'(`STROBE_CYCLES - 1));
    wire recovEnd  = (count == 4'(`RECOVER_CYCLES - 1));

    assign cyc.rdata = rdataReg;
    assign cyc.done  = doneReg;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state          <= BUS_IDLE;
            count          <= 4'h0;
            isWrite        <= 1'b0;
            flashAddr      <= '0;
            dataOut        <= 16'h0000;
            dataOe_b       <= 1'b1;
            chipSelect_b   <= 1'b1;
            outputEnable_b <= 1'b1;
            writeStrobe_b  <= 1'b1;
            rdataReg       <= 16'h0000;
            doneReg        <= 1'b0;
        end else begin
            doneReg <= 1'b0;
            case (state)
                BUS_IDLE: begin
                    count <= 4'h0;
                    if (cyc.req && !doneReg) begin
                        state          <= BUS_STROBE;
                        isWrite        <= cyc.write;
                        flashAddr      <= cyc.addr[ADDR_W-1:0];
                        dataOut        <= cyc.wdata;
                        dataOe_b       <= !cyc.write;
                        chipSelect_b   <= 1'b0;
                        outputEnable_b <= cyc.write;
                        writeStrobe_b  <= !cyc.write;
                    end
                end
                BUS_STROBE: begin
                    count <= count + 4'h1;
                    if (strobeEnd) begin
                        // Sample read data at end of strobe; one full word
                        if (!isWrite) begin
                            rdataReg <= dataIn;
                        end
                        count          <= 4'h0;
                        state          <= BUS_RECOV;
                        chipSelect_b   <= 1'b1;
                        outputEnable_b <= 1'b1;
                        writeStrobe_b  <= 1'b1;
                    end
                end
                BUS_RECOV: begin
                    count <= count + 4'h1;
                    // Data held through recovery for write hold time
                    if (recovEnd) begin
                        dataOe_b <= 1'b1;
                        doneReg  <= 1'b1;
                        state    <= BUS_IDLE;
                    end
                end
                default: begin
                    state <= BUS_IDLE;
                end
            endcase
        end
    end
endmodule : flash_bus_cycle

// file: flash_cycle_if.sv
`timescale 1ns/10ps
interface flash_cycle_if;
    import flash_status_pkg::*;
    logic        req;
    logic        write;
    logic [21:0] addr;
    flash_word_t wdata;
    flash_word_t rdata;
    logic        done;

    modport master (output req, output write, output addr, output wdata,
                    input rdata, input done);
    modport engine (input req, input write, input addr, input wdata,
                    output rdata, output done);
endinterface : flash_cycle_if

// file: flash_device_model.sv
`timescale 1ns/10ps
module flash_device_model (
    input  wire logic        outputEnable_b,
    input  wire logic        writeStrobe_b,
    input  wire logic        chipSelect_b,
    input  wire logic [15:0] dataOut,
    input  wire logic        launch,
    input  wire logic        eraseOp,
    input  wire logic        stall,
    input  wire logic [7:0]  busyReads,
    input  wire logic [15:0] arrayWord,
    output logic [15:0]      dataIn,
    output logic             readyBusyPin,
    output logic             sawReset
);
    logic        busy     = 1'b0;
    logic        toggleFf = 1'b0;
    logic        timedOut = 1'b0;
    logic [7:0]  readsLeft;
    logic [15:0] word;

    // no protected sectors: status valid at any address
    assign word = busy ? {8'h00, ~eraseOp & ~arrayWord[7], toggleFf,
                          timedOut, 2'b00, eraseOp & toggleFf, 2'b00}
                       : arrayWord;
    // Released bus inverts, so a stale word never passes
    assign dataIn = (!chipSelect_b && !outputEnable_b) ? word : ~word;
    assign readyBusyPin = busy ? 1'b0 : 1'b1;

    initial sawReset = 1'b0;
    always @(posedge launch) begin
        busy = 1'b1;
        timedOut = 1'b0;
        sawReset = 1'b0;
        readsLeft = busyReads;
    end
    always @(posedge outputEnable_b) begin
        if (busy) begin
            toggleFf = !toggleFf;
            if (readsLeft != 8'h00) begin
                readsLeft = readsLeft - 8'h01;
            end else if (stall) begin
                timedOut = 1'b1;
            end else begin
                busy = 1'b0;
            end
        end
    end
    always @(posedge writeStrobe_b) begin
        if (dataOut[7:0] == 8'hf0) begin
            busy = 1'b0;
            timedOut = 1'b0;
            sawReset = 1'b1;
        end
    end
endmodule : flash_device_model

// file: flash_status_defs.svh
`ifndef FLASH_STATUS_DEFS_SVH
`define FLASH_STATUS_DEFS_SVH

// Register byte offsets on APB
`define REG_CTRL_OFF      12'h000
`define REG_ADDR_OFF      12'h004
`define REG_DATA_OFF      12'h008
`define REG_STATUS_OFF    12'h00c
`define REG_RESULT_OFF    12'h010

// CTRL fields
`define CTRL_GO_BIT       0
`define CTRL_MODE_LO      1
`define CTRL_MODE_HI      2
`define CTRL_ABORT_BIT    3

// STATUS fields
`define ST_BUSY_BIT       0
`define ST_DONE_BIT       1
`define ST_FAIL_BIT       2
`define ST_READY_BIT      3

// Data bit positions on the flash bus
`define POLL_BIT_POS      7
`define TOGGLE_BIT_POS    6
`define TIMEOUT_BIT_POS   5
`define SECTOR_TOGGLE_POS 2

// Commands and values
`define RESET_CMD         16'h00f0
`define CTRL_RESET_VAL    32'h0000_0000

// Bus timing: clock is 10 MHz, 100 ns
`define CLK_PERIOD_NS     100
`define STROBE_NS         100
`define STROBE_CYCLES     ((`STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_NS        100
`define RECOVER_CYCLES    ((`RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: flash_status_pkg.sv
package flash_status_pkg;

    typedef enum logic [1:0] {
        MODE_POLL   = 2'b00,
        MODE_TOGGLE = 2'b01,
        MODE_RESET  = 2'b10,
        MODE_READ   = 2'b11
    } poll_mode_e;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b00,
        BUS_STROBE = 2'b01,
        BUS_RECOV  = 2'b10
    } bus_state_e;

    typedef logic [15:0] flash_word_t;

endpackage : flash_status_pkg

// file: flash_write_status_reporting.sv
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "flash_status_defs.svh"
module flash_write_status_reporting
    import flash_status_pkg::*;
#(
    parameter int ADDR_W = 22
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [ADDR_W-1:0]      flashAddr,
    output logic [15:0]            dataOut,
    output logic                   dataOe_b,
    input  wire logic [15:0]       dataIn,
    output logic                   chipSelect_b,
    output logic                   outputEnable_b,
    output logic                   writeStrobe_b,
    input  wire logic              ready_busy_pin
);
    typedef enum logic [3:0] {
        ST_IDLE    = 4'b0000,
        ST_READ1   = 4'b0001,
        ST_READ2   = 4'b0010,
        ST_CHECK   = 4'b0011,
        ST_RECHK1  = 4'b0100,
        ST_RECHK2  = 4'b0101,
        ST_FINAL   = 4'b0110,
        ST_RESET   = 4'b0111,
        ST_FAIL    = 4'b1000,
        ST_DONE    = 4'b1001
    } host_state_e;

    host_state_e  state;
    host_state_e  next_state;
    poll_mode_e   mode;
    logic [21:0]  targetAddr;
    flash_word_t  expectData;
    flash_word_t  firstRead;
    flash_word_t  resultWord;
    logic         busy;
    logic         doneFlag;
    logic         failFlag;
    logic         readyPin;
    logic         startPend;
    logic         abortPend;

    flash_cycle_if cyc ();

    flash_bus_cycle #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .clk            (clk),
        .rst_b          (rst_b),
        .cyc            (cyc),
        .flashAddr      (flashAddr),
        .dataOut        (dataOut),
        .dataOe_b       (dataOe_b),
        .dataIn         (dataIn),
        .chipSelect_b   (chipSelect_b),
        .outputEnable_b (outputEnable_b),
        .writeStrobe_b  (writeStrobe_b)
    );

    // APB decode; single-cycle access answer
    wire apbAccess = psel && penable;
    wire apbWrite  = apbAccess && pwrite;
    wire selCtrl   = (paddr == `REG_CTRL_OFF);
    wire selAddr   = (paddr == `REG_ADDR_OFF);
    wire selData   = (paddr == `REG_DATA_OFF);
    wire selStatus = (paddr == `REG_STATUS_OFF);
    wire selResult = (paddr == `REG_RESULT_OFF);
    wire selAny    = selCtrl | selAddr | selData | selStatus | selResult;
    wire goWrite   = apbWrite && selCtrl && pwdata[`CTRL_GO_BIT];
    wire abortWr   = apbWrite && selCtrl && pwdata[`CTRL_ABORT_BIT];
    wire [31:0] statusWord = {28'h0, readyPin, failFlag, doneFlag, busy};
    wire [31:0] readMux =
        selCtrl   ? {29'h0, mode, 1'b0} :
        selAddr   ? {10'h0, targetAddr} :
        selData   ? {16'h0, expectData} :
        selStatus ? statusWord :
        selResult ? {16'h0, resultWord} : 32'h0;

    // Bit extraction from the last word read
    wire flash_word_t lastRead = cyc.rdata;
    wire toggleDiff = lastRead[`TOGGLE_BIT_POS] != firstRead[`TOGGLE_BIT_POS];
    wire timeoutHi  = lastRead[`TIMEOUT_BIT_POS];
    wire pollTrue   = lastRead[`POLL_BIT_POS] == expectData[`POLL_BIT_POS];
    wire cycDone    = cyc.done;
    wire isPoll     = (mode == MODE_POLL);
    // Toggle mode stops when the bit is steady; poll mode when data is true
    wire opDone     = isPoll ? pollTrue : !toggleDiff;

    assign cyc.req   = (state == ST_READ1) || (state == ST_READ2) ||
                       (state == ST_RECHK1) || (state == ST_RECHK2) ||
                       (state == ST_FINAL) || (state == ST_RESET);
    assign cyc.write = (state == ST_RESET);
    assign cyc.addr  = targetAddr;
    assign cyc.wdata = (state == ST_RESET) ? `RESET_CMD : expectData;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (startPend) begin
                    next_state = (mode == MODE_RESET) ? ST_RESET : ST_READ1;
                end
            end
            ST_READ1: begin
                if (cycDone) begin
                    next_state = (mode == MODE_READ) ? ST_DONE : ST_READ2;
                end
            end
            ST_READ2: begin
                if (cycDone) begin
                    next_state = ST_CHECK;
                end
            end
            ST_CHECK: begin
                // full word from a later read
                if (opDone) begin
                    next_state = ST_FINAL;
                end else if (timeoutHi) begin
                    next_state = ST_RECHK1;
                end else if (abortPend) begin
                    next_state = ST_IDLE;
                end else begin
                    next_state = ST_READ1;
                end
            end
            ST_RECHK1: begin
                if (cycDone) begin
                    next_state = ST_RECHK2;
                end
            end
            ST_RECHK2: begin
                if (cycDone) begin
                    next_state = opDone ? ST_FINAL : ST_FAIL;
                end
            end
            ST_FINAL: begin
                if (cycDone) begin
                    next_state = ST_DONE;
                end
            end
            ST_FAIL: begin
                next_state = ST_RESET;
            end
            ST_RESET: begin
                if (cycDone) begin
                    next_state = ST_DONE;
                end
            end
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            firstRead  <= 16'h0000;
            resultWord <= 16'h0000;
        end else begin
            if (state == ST_READ1 && cycDone) begin
                firstRead <= cyc.rdata;
            end
            if (state == ST_RECHK1 && cycDone) begin
                firstRead <= cyc.rdata;
            end
            if ((state == ST_FINAL || state == ST_READ1) && cycDone) begin
                resultWord <= cyc.rdata;
            end
        end
    end

    // Status flags: done and fail set by hardware, cleared by a new start
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy      <= 1'b0;
            doneFlag  <= 1'b0;
            failFlag  <= 1'b0;
            startPend <= 1'b0;
            abortPend <= 1'b0;
            readyPin  <= 1'b1;
        end else begin
            readyPin <= ready_busy_pin;
            if (goWrite && !busy) begin
                startPend <= 1'b1;
                busy      <= 1'b1;
                doneFlag  <= 1'b0;
                failFlag  <= 1'b0;
            end else if (state == ST_IDLE) begin
                startPend <= 1'b0;
            end
            if (abortWr && busy) begin
                abortPend <= 1'b1;
            end else if (state == ST_IDLE) begin
                abortPend <= 1'b0;
            end
            if (state == ST_FAIL) begin
                failFlag <= 1'b1;
            end
            if (state == ST_DONE) begin
                doneFlag <= 1'b1;
                busy     <= 1'b0;
            end else if (state == ST_CHECK && next_state == ST_IDLE) begin
                busy <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode       <= MODE_POLL;
            targetAddr <= 22'h0;
            expectData <= 16'h0000;
        end else if (apbWrite && !busy) begin
            if (selCtrl) begin
                mode <= poll_mode_e'(pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO]);
            end
            if (selAddr) begin
                targetAddr <= pwdata[21:0];
            end
            if (selData) begin
                expectData <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prdata  <= 32'h0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !selAny;
            prdata  <= (psel && !pwrite) ? readMux : 32'h0;
        end
    end
endmodule : flash_write_status_reporting

// file: flash_write_status_reporting_assertions.sv
`timescale 1ns/10ps
module flash_status_checker #(
    parameter int ADDR_W = 22
) (
    input wire logic              clk,
    input wire logic              rst_b,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [ADDR_W-1:0] flashAddr,
    input wire logic [15:0]       dataOut,
    input wire logic              dataOe_b,
    input wire logic              chipSelect_b,
    input wire logic              outputEnable_b,
    input wire logic              writeStrobe_b
);
    logic mapped;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    assign mapped = paddr inside {12'h000, 12'h004, 12'h008, 12'h00c, 12'h010};

    AST_READ_ONE: assert property ($fell(outputEnable_b) |=> $rose(outputEnable_b))
        else $error("read strobe not one cycle");
    AST_READ_CLEAN: assert property (!outputEnable_b |->
        !chipSelect_b && writeStrobe_b && dataOe_b)
        else $error("read strobe with bad companions");
    AST_ADDR_HELD: assert property (!outputEnable_b |=> $stable(flashAddr))
        else $error("flash address moved during read");
    AST_WRITE_RESET: assert property (!writeStrobe_b |->
        dataOut == 16'h00f0 && !dataOe_b && !chipSelect_b)
        else $error("write strobe without reset command");
    AST_WRITE_ONE: assert property ($fell(writeStrobe_b) |=> writeStrobe_b[*2])
        else $error("write strobe or recovery wrong length");
    AST_ANSWER: assert property (psel && !penable |=> pready && psel && penable)
        else $error("no answer in access cycle");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (pready |-> pslverr == !mapped)
        else $error("error response does not match address");
    AST_ERR_ZERO: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
endmodule : flash_status_checker

// file: flash_write_status_reporting_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) \
    begin \
        n_checks++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
        end \
    end
module flash_write_status_reporting_tb_top;
    logic        clk       = 1'b0;
    logic        rst_b     = 1'b0;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = 12'h000;
    logic [31:0] pwdata    = 32'h0;
    logic        launch    = 1'b0;
    logic        eraseOp   = 1'b0;
    logic        stall     = 1'b0;
    logic [7:0]  busyReads = 8'h00;
    logic [15:0] arrayWord = 16'h0000;
    logic [31:0] seed      = 32'hfe07;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [21:0] flashAddr;
    logic [15:0] dataOut;
    logic        dataOe_b;
    logic [15:0] dataIn;
    logic        chipSelect_b;
    logic        outputEnable_b;
    logic        writeStrobe_b;
    logic        ready_busy_pin;
    logic        sawReset;
    logic [31:0] rd;
    logic [21:0] pollAddr;
    logic [32:0] expNote;
    logic [32:0] gotNote;
    logic [65:0] noteQ[$];
    logic [11:0] ops[6] = '{12'h000, 12'h005, 12'h204, 12'h403, 12'h606,
                            12'h502};
    int          n_errors  = 0;
    int          n_checks  = 0;

    flash_write_status_reporting #(.ADDR_W(22)) dut_u (
        .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .flashAddr, .dataOut, .dataOe_b, .dataIn,
        .chipSelect_b, .outputEnable_b, .writeStrobe_b, .ready_busy_pin
    );
    flash_device_model model_u (
        .outputEnable_b, .writeStrobe_b, .chipSelect_b, .dataOut, .launch,
        .eraseOp, .stall, .busyReads, .arrayWord, .dataIn, .sawReset,
        .readyBusyPin(ready_busy_pin)
    );

    always #50 clk = ~clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // One APB transfer; a read files its expectation first
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] v,
                       input logic [32:0] m);
        int n;
        n = 0;
        if (!w) noteQ.push_back({v, m});
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            test_done();
        end
    endtask : apb

    task automatic wait_idle();
        int k;
        k = 0;
        do begin
            apb(1'b0, 12'h00c, 32'h0, 33'h0, 33'h1_0000_0000);
            k++;
        end while (rd[0] !== 1'b0 && k < 300);
        if (k >= 300) begin
            n_errors++;
            test_done();
        end
    endtask : wait_idle

    task automatic run_op(input logic [11:0] op);
        seed = lfsr(seed);
        arrayWord <= op[9] ? 16'hffff : seed[15:0];
        eraseOp   <= op[9];
        stall     <= op[8];
        busyReads <= op[7:0];
        launch    <= 1'b1;
        apb(1'b1, 12'h008, {16'h0, op[9] ? 16'hffff : seed[15:0]}, 0, 0);
        launch <= 1'b0;
        apb(1'b0, 12'h00c, 32'h0, 33'h0, 33'h8);
        apb(1'b1, 12'h000, {29'h0, 1'b0, op[10], 1'b1}, 0, 0);
        wait_idle();
        `CHK("flash address", pollAddr, flashAddr)
        // Ready pin back high; fail only for a stalled operation
        apb(1'b0, 12'h00c, 0, {29'h0, 1'b1, op[8], 2'b10},
            33'h1_0000_000f);
        if (op[8]) begin
            `CHK("reset command", 1'b1, sawReset)
        end else begin
            apb(1'b0, 12'h010, 0, {17'h0, arrayWord}, 33'h1_0000_ffff);
        end
    endtask : run_op

    // Results are compared in the order they were requested
    always @(posedge clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            expNote = noteQ[0][65:33] & noteQ[0][32:0];
            gotNote = {pslverr, prdata} & noteQ[0][32:0];
            `CHK("apb read", expNote, gotNote)
            void'(noteQ.pop_front());
        end
    end

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        apb(1'b0, 12'h000, 0, 33'h0, 33'h1_ffff_ffff);
        apb(1'b0, 12'h00c, 0, 33'h8, 33'h1_ffff_ffff);
        apb(1'b0, 12'h020, 0, 33'h1_0000_0000, 33'h1_ffff_ffff);
        seed = lfsr(seed);
        apb(1'b1, 12'h004, seed, 0, 0);
        pollAddr = seed[21:0];
        apb(1'b0, 12'h004, 0, {11'h0, seed[21:0]}, 33'h1_003f_ffff);
        $display("test registers done");
        for (int i = 0; i < 6; i++) begin
            run_op(ops[i]);
        end
        $display("test operations done");
        busyReads <= 8'hc8;
        launch    <= 1'b1;
        apb(1'b1, 12'h000, 32'h3, 0, 0);
        launch <= 1'b0;
        apb(1'b1, 12'h000, 32'h8, 0, 0);
        wait_idle();
        apb(1'b0, 12'h00c, 0, 33'h0, 33'h6);
        apb(1'b1, 12'h000, 32'h5, 0, 0);
        wait_idle();
        apb(1'b0, 12'h00c, 0, 33'h8, 33'h8);
        `CHK("reset command", 1'b1, sawReset)
        $display("test abort done");
        seed = lfsr(seed);
        arrayWord <= seed[15:0];
        apb(1'b1, 12'h000, 32'h7, 0, 0);
        wait_idle();
        apb(1'b0, 12'h010, 0, {17'h0, arrayWord}, 33'h1_0000_ffff);
        $display("test array read done");
        test_done();
    end
endmodule : flash_write_status_reporting_tb_top

bind flash_write_status_reporting flash_status_checker #(.ADDR_W(ADDR_W)) chk_u (
    .clk, .rst_b, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .flashAddr, .dataOut, .dataOe_b, .chipSelect_b, .outputEnable_b,
    .writeStrobe_b
);
